// File: dwd_cfg.svh
// constants for the display word decoder
// Functional notes
// - 30-bit words, code in bits 29..26
// - code 00 skipped, next word requested
// - position X bits 22..15, Y 7..0
// - first char code from bits 20..15
// - second char code from bits 5..0
// - code 02 point then centred special char
// - only eight codes count as special
// - code 03 point, first char quarter inch right
// - lone second char half inch from point
// - code 04 type format, quarter inch chained
// - vector X from bits 23..15
// - vector Y from bits 8..0
// - code 05 vector centred, nine-bit components
// - code 06 half inch heading vector
// - code 06 after 02 reuses position
// - circle centred, unsigned radius, 377 diameter
// - code 10 ends frame data
// - no end word: keep buffered content
// - codes 12,13,14 flash versions of 02,03,04
// - flash half second on, half off
`ifndef DWD_CFG_SVH
`define DWD_CFG_SVH
`define DWD_WORD_W 30
`define DWD_FC_HI 29
`define DWD_FC_LO 26
`define DWD_POS_X_HI 22
`define DWD_POS_X_LO 15
`define DWD_POS_Y_HI 7
`define DWD_POS_Y_LO 0
`define DWD_C1_HI 20
`define DWD_C1_LO 15
`define DWD_C2_HI 5
`define DWD_C2_LO 0
`define DWD_VEC_X_HI 23
`define DWD_VEC_X_LO 15
`define DWD_VEC_Y_HI 8
`define DWD_VEC_Y_LO 0
`define DWD_FIFO_DEPTH 16
`define DWD_CLK_MHZ 250
`define DWD_FLASH_HALF_MS 500
`define DWD_FLASH_CYC (`DWD_FLASH_HALF_MS * 1000 * `DWD_CLK_MHZ)
`define DWD_OFS_QUARTER 8'h08
`define DWD_OFS_HALF 8'h10
`define DWD_HEADING_LEN 6'h10
`endif

// File: dwd_pkg.sv
// types shared by the display word decoder
package dwd_pkg;
  typedef enum logic [3:0] {
    DWD_FC_NOP = 4'h0, DWD_FC_POS = 4'h1, DWD_FC_CH1 = 4'h2,
    DWD_FC_CH2 = 4'h3, DWD_FC_TYPE = 4'h4, DWD_FC_VEC = 4'h5,
    DWD_FC_AZ = 4'h6, DWD_FC_CIRC = 4'h7, DWD_FC_EOD = 4'h8,
    DWD_FC_CH1F = 4'ha, DWD_FC_CH2F = 4'hb, DWD_FC_TYPEF = 4'hc
  } dwd_fc_t;
  typedef enum logic [2:0] {
    DWD_ACT_NONE = 3'h0, DWD_ACT_POINT = 3'h1, DWD_ACT_CHAR = 3'h2,
    DWD_ACT_VEC = 3'h3, DWD_ACT_AZ = 3'h4, DWD_ACT_CIRC = 3'h5
  } dwd_act_t;
  typedef struct packed {
    dwd_act_t act;
    logic [7:0] x;
    logic [7:0] y;
    logic [8:0] dx;
    logic [8:0] dy;
    logic [5:0] char_code;
    logic flash;
  } dwd_cmd_t;
endpackage

// File: dwd_fifo.sv
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ps
module dwd_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset, high
  input wire logic [WIDTH-1:0] in_data, // word in
  input wire logic in_valid, // word offered
  output logic in_ready, // space left
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // head valid
  input wire logic out_ready // head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  // honest flags from the fill count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];
  // storage has no reset, pointers do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// File: dwd_decoder.sv
// display word decoder: computer words in, plotting commands out
`timescale 1ns/1ps
`include "dwd_cfg.svh"
module dwd_decoder (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rst, // async reset, high
  input wire logic [29:0] word_in, // word from computer
  input wire logic word_valid, // word offered
  output logic word_req, // fifo has room, request next word
  input wire logic frame_start, // frame reinitialisation strobe
  output dwd_pkg::dwd_cmd_t cmd_out, // plotting command
  output logic cmd_valid, // command strobe
  input wire logic cmd_ready, // plotter accepts command
  output logic video_en, // z axis video enable
  output logic frame_done, // end of data seen this frame
  output logic special_err // bad special character code
);
  logic [29:0] head;
  logic head_valid, head_pop, fifo_ready;
  logic fs_m_q, fs_s_q, fs_d_q;
  logic frame_pulse;
  // frame strobe comes from the timing unit, another domain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fs_m_q <= 1'b0;
      fs_s_q <= 1'b0;
      fs_d_q <= 1'b0;
    end else begin
      fs_m_q <= frame_start;
      fs_s_q <= fs_m_q;
      fs_d_q <= fs_s_q;
    end
  end
  assign frame_pulse = fs_s_q && !fs_d_q;

  // words queue here; stalled plotter back-pressures the computer
  dwd_fifo #(.WIDTH(`DWD_WORD_W), .DEPTH(`DWD_FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .in_data(word_in),
    .in_valid(word_valid),
    .in_ready(fifo_ready),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(head_pop)
  );

  // field extraction
  wire [3:0] fc = head[`DWD_FC_HI:`DWD_FC_LO];
  wire [7:0] pos_x = head[`DWD_POS_X_HI:`DWD_POS_X_LO];
  wire [7:0] pos_y = head[`DWD_POS_Y_HI:`DWD_POS_Y_LO];
  wire [5:0] c1 = head[`DWD_C1_HI:`DWD_C1_LO];
  wire [5:0] c2 = head[`DWD_C2_HI:`DWD_C2_LO];
  wire [8:0] vec_x = head[`DWD_VEC_X_HI:`DWD_VEC_X_LO];
  wire [8:0] vec_y = head[`DWD_VEC_Y_HI:`DWD_VEC_Y_LO];
  wire flash_fc = fc[3] && (fc[2:0] != 3'h0);
  wire [2:0] base_fc = fc[2:0];

  // special character set for single-character mode
  wire c1_special = (c1 == 6'h00) || (c1 == 6'h0b) || (c1 == 6'h0c) ||
    (c1 == 6'h0d) || (c1 == 6'h0e) || (c1 == 6'h0f) ||
    (c1 == 6'h21) || (c1 == 6'h24);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SECOND = 3'b001,
    ST_THIRD = 3'b010,
    ST_HOLD = 3'b011,
    ST_DONE = 3'b100
  } st_t;
  st_t st_q, st_d;
  logic [7:0] ref_x_q, ref_x_d, ref_y_q, ref_y_d;
  logic [7:0] type_x_q, type_x_d;
  logic type_ok_q, type_ok_d;
  logic [29:0] cur_q, cur_d;
  logic frame_done_q, frame_done_d;
  logic err_q, err_d;
  dwd_pkg::dwd_cmd_t cmd_q, cmd_d;
  logic cmd_v_q, cmd_v_d;
  logic pop_d;

  wire out_free = !cmd_v_q || cmd_ready;
  wire take = head_valid && out_free && (st_q == ST_IDLE) &&
    !frame_done_q;
  wire [3:0] cfc = cur_q[`DWD_FC_HI:`DWD_FC_LO];
  wire [5:0] cc1 = cur_q[`DWD_C1_HI:`DWD_C1_LO];
  wire [5:0] cc2 = cur_q[`DWD_C2_HI:`DWD_C2_LO];
  wire cflash = cfc[3];
  assign head_pop = pop_d;

  // build one command from a reference point
  function automatic dwd_pkg::dwd_cmd_t mk(dwd_pkg::dwd_act_t a,
      logic [7:0] x, logic [7:0] y, logic [5:0] ch, logic fl);
    dwd_pkg::dwd_cmd_t c;
    c = '0;
    c.act = a;
    c.x = x;
    c.y = y;
    c.char_code = ch;
    c.flash = fl;
    return c;
  endfunction

  // word decode and multi-step sequencing
  always_comb begin
    st_d = st_q;
    ref_x_d = ref_x_q;
    ref_y_d = ref_y_q;
    type_x_d = type_x_q;
    type_ok_d = type_ok_q;
    cur_d = cur_q;
    frame_done_d = frame_done_q;
    err_d = err_q;
    cmd_d = cmd_q;
    cmd_v_d = cmd_v_q && !cmd_ready;
    pop_d = 1'b0;
    // after reinit decoding resumes with whatever is still queued
    if (frame_pulse) begin
      frame_done_d = 1'b0;
    end
    if (take) begin
      pop_d = 1'b1;
      cur_d = head;
      if (fc == 4'h0) begin
        // nothing emitted, next word drawn next cycle
        cmd_v_d = 1'b0;
      end else if (fc == 4'h1) begin
        ref_x_d = pos_x;
        ref_y_d = pos_y;
        type_ok_d = 1'b0;
      end else if (fc == 4'h8) begin
        frame_done_d = 1'b1;
      end else if (base_fc == 3'h2 && (flash_fc || !fc[3])) begin
        cmd_d = mk(dwd_pkg::DWD_ACT_POINT, ref_x_q, ref_y_q, 6'h00,
          1'b0);
        cmd_v_d = 1'b1;
        err_d = !c1_special;
        st_d = ST_SECOND;
      end else if (base_fc == 3'h3 && (flash_fc || !fc[3])) begin
        cmd_d = mk(dwd_pkg::DWD_ACT_POINT, ref_x_q, ref_y_q, 6'h00,
          1'b0);
        cmd_v_d = 1'b1;
        st_d = ST_SECOND;
      end else if (base_fc == 3'h4 && (flash_fc || !fc[3])) begin
        // chained from previous type word or last position
        cmd_d = mk(dwd_pkg::DWD_ACT_CHAR,
          (type_ok_q ? type_x_q : ref_x_q) + `DWD_OFS_QUARTER,
          ref_y_q, c1, flash_fc);
        cmd_v_d = 1'b1;
        type_x_d = (type_ok_q ? type_x_q : ref_x_q) + `DWD_OFS_QUARTER;
        type_ok_d = 1'b1;
        st_d = (c2 != 6'h00) ? ST_SECOND : ST_IDLE;
      end else if (fc == 4'h5) begin
        cmd_d = mk(dwd_pkg::DWD_ACT_VEC, ref_x_q, ref_y_q, 6'h00, 1'b0);
        cmd_d.dx = vec_x;
        cmd_d.dy = vec_y;
        cmd_v_d = 1'b1;
      end else if (fc == 4'h6) begin
        // position kept, so an 02 word may precede it directly
        cmd_d = mk(dwd_pkg::DWD_ACT_AZ, ref_x_q, ref_y_q,
          `DWD_HEADING_LEN, 1'b0);
        cmd_d.dx = vec_x;
        cmd_d.dy = vec_y;
        cmd_v_d = 1'b1;
      end else if (fc == 4'h7) begin
        // radius from the low half; high half is a copy
        cmd_d = mk(dwd_pkg::DWD_ACT_CIRC, ref_x_q, ref_y_q, 6'h00, 1'b0);
        cmd_d.dx = {1'b0, pos_y};
        cmd_d.dy = {1'b0, pos_x};
        cmd_v_d = 1'b1;
      end
    end else if (out_free && st_q == ST_SECOND) begin
      cmd_v_d = 1'b1;
      st_d = ST_IDLE;
      if (cfc[2:0] == 3'h2) begin
        // centred special character, second slot blank
        cmd_d = mk(dwd_pkg::DWD_ACT_CHAR, ref_x_q, ref_y_q, cc1,
          cflash);
      end else if (cfc[2:0] == 3'h3) begin
        if (cc1 == 6'h00) begin
          cmd_d = mk(dwd_pkg::DWD_ACT_CHAR, ref_x_q + `DWD_OFS_HALF,
            ref_y_q, cc2, cflash);
        end else begin
          cmd_d = mk(dwd_pkg::DWD_ACT_CHAR, ref_x_q + `DWD_OFS_QUARTER,
            ref_y_q, cc1, cflash);
          st_d = (cc2 != 6'h00) ? ST_THIRD : ST_IDLE;
        end
      end else begin
        cmd_d = mk(dwd_pkg::DWD_ACT_CHAR, type_x_q + `DWD_OFS_QUARTER,
          ref_y_q, cc2, cflash);
        type_x_d = type_x_q + `DWD_OFS_QUARTER;
      end
    end else if (out_free && st_q == ST_THIRD) begin
      cmd_d = mk(dwd_pkg::DWD_ACT_CHAR, ref_x_q + `DWD_OFS_HALF,
        ref_y_q, cc2, cflash);
      cmd_v_d = 1'b1;
      st_d = ST_IDLE;
    end
  end

  // sequencing state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      ref_x_q <= 8'h00;
      ref_y_q <= 8'h00;
      type_x_q <= 8'h00;
      type_ok_q <= 1'b0;
      cur_q <= 30'h0;
      frame_done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ref_x_q <= ref_x_d;
      ref_y_q <= ref_y_d;
      type_x_q <= type_x_d;
      type_ok_q <= type_ok_d;
      cur_q <= cur_d;
      frame_done_q <= frame_done_d;
      err_q <= err_d;
    end
  end

  // command register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_q <= '0;
      cmd_v_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      cmd_v_q <= cmd_v_d;
    end
  end

  // flash timer: half second on, half off; counted freely so all
  // flashing text blinks in step
  logic [27:0] fl_cnt_q;
  logic fl_on_q;
  wire fl_wrap = (fl_cnt_q == 28'(`DWD_FLASH_CYC - 1));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fl_cnt_q <= 28'h0;
      fl_on_q <= 1'b1;
    end else begin
      fl_cnt_q <= fl_wrap ? 28'h0 : fl_cnt_q + 28'h1;
      fl_on_q <= fl_wrap ? !fl_on_q : fl_on_q;
    end
  end

  // video gate for the command on display
  logic video_q, req_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      video_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      video_q <= cmd_v_q && (!cmd_q.flash || fl_on_q);
      req_q <= fifo_ready;
    end
  end

  assign cmd_out = cmd_q;
  assign cmd_valid = cmd_v_q;
  assign video_en = video_q;
  assign word_req = req_q;
  assign frame_done = frame_done_q;
  assign special_err = err_q;
endmodule

// File: dwd_host_model.sv
// host model: offers queued display words while the decoder asks
`timescale 1ns/1ps
module dwd_host_model (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset, high
  input wire logic word_req, // decoder wants a word
  output logic [29:0] word_in, // word to decoder
  output logic word_valid, // word offered
  output int taken // words accepted so far
);
  logic [29:0] q[$];
  logic acc;
  task automatic push(input logic [29:0] w);
    q.push_back(w);
  endtask
  initial begin
    word_in = 30'h0;
    word_valid = 0;
    taken = 0;
    acc = 0;
  end
  // a word counts as taken only at an edge that saw word_req high
  always @(posedge sys_clk) begin
    if (!rst && word_valid && word_req) acc = 1;
  end
  // one idle cycle after each word lets the lagging word_req catch up
  always @(negedge sys_clk) begin
    if (acc) begin
      void'(q.pop_front());
      taken++;
      acc = 0;
      word_valid <= 0;
      word_in <= ~word_in;
    end else if (!word_valid && q.size() > 0 && word_req) begin
      word_valid <= 1;
      word_in <= q[0];
    end else if (!word_valid) begin
      word_in <= ~word_in;
    end
  end
endmodule

// File: dwd_decoder_sva.sv
// checker for the decoder's command and status ports
`timescale 1ns/1ps
module dwd_decoder_sva (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset, high
  input wire logic frame_start, // frame strobe
  input wire dwd_pkg::dwd_cmd_t cmd_out, // command
  input wire logic cmd_valid, // command strobe
  input wire logic cmd_ready, // plotter accepts
  input wire logic video_en, // z axis enable
  input wire logic frame_done // end of data seen
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  cmd_hold_a: assert property (
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_out))
    else $error("command changed before accept");
  no_empty_a: assert property (
    cmd_valid |-> cmd_out.act != dwd_pkg::DWD_ACT_NONE)
    else $error("empty command emitted");
  az_len_a: assert property (
    cmd_valid && cmd_out.act == dwd_pkg::DWD_ACT_AZ
      |-> cmd_out.char_code == 6'h10)
    else $error("heading length wrong");
  circ_sign_a: assert property (
    cmd_valid && cmd_out.act == dwd_pkg::DWD_ACT_CIRC
      |-> !cmd_out.dx[8] && !cmd_out.dy[8])
    else $error("circle radius signed");
  flash_kind_a: assert property (
    cmd_valid && cmd_out.flash
      |-> cmd_out.act inside {dwd_pkg::DWD_ACT_POINT, dwd_pkg::DWD_ACT_CHAR})
    else $error("flash on non character");
  video_src_a: assert property (
    video_en |-> $past(cmd_valid))
    else $error("video without command");
  video_on_a: assert property (
    cmd_valid && !cmd_out.flash |=> video_en)
    else $error("steady video missing");
  eod_hold_a: assert property (
    (!frame_start) [*5] ##0 frame_done |=> frame_done)
    else $error("end of data lost without frame");
endmodule
bind dwd_decoder dwd_decoder_sva i_sva (.sys_clk(sys_clk), .rst(rst),
  .frame_start(frame_start), .cmd_out(cmd_out), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .video_en(video_en), .frame_done(frame_done));

// File: dwd_decoder_tb.sv
// self-checking bench for the display word decoder
`timescale 1ns/1ps
module dwd_decoder_tb;
  logic sys_clk, rst, frame_start, cmd_ready, word_valid, word_req;
  logic cmd_valid, video_en, frame_done, special_err;
  logic [29:0] word_in;
  dwd_pkg::dwd_cmd_t cmd_out, c;
  int err_count, n_checks, taken, i;
  logic [5:0] spc [8] = '{6'h00, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f,
    6'h21, 6'h24};
  dwd_decoder i_dut (.sys_clk(sys_clk), .rst(rst), .word_in(word_in),
    .word_valid(word_valid), .word_req(word_req),
    .frame_start(frame_start), .cmd_out(cmd_out), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .video_en(video_en), .frame_done(frame_done),
    .special_err(special_err));
  dwd_host_model i_host (.sys_clk(sys_clk), .rst(rst), .word_req(word_req),
    .word_in(word_in), .word_valid(word_valid), .taken(taken));
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // word builder: code, bits 23..15, bits 8..0
  function automatic logic [29:0] w(input logic [3:0] f,
    input logic [8:0] h, l);
    return {f, 2'h0, h, 6'h00, l};
  endfunction
  // take one command; ready rises off the edge, a hang ends the run
  task automatic ex(input dwd_pkg::dwd_act_t a, input logic [7:0] x, y,
    input logic [6:0] cc);
    int k;
    @(negedge sys_clk) cmd_ready = 1;
    for (k = 0; k < 300 && cmd_valid !== 1'b1; k++) @(negedge sys_clk);
    if (k == 300) begin
      err_count++;
      report_and_stop();
    end
    c = cmd_out;
    @(negedge sys_clk) cmd_ready = 0;
    check("act", c.act, a);
    check("x", c.x, x);
    check("y", c.y, y);
    if (!cc[6]) check("code", c.char_code, cc);
  endtask
  task automatic s_vec();
    i_host.push(w(4'h1, 9'h012, 9'h034));
    i_host.push(w(4'h5, 9'h1ab, 9'h055));
    ex(dwd_pkg::DWD_ACT_VEC, 8'h12, 8'h34, 7'h40);
    check("dx", c.dx, 9'h1ab);
    check("dy", c.dy, 9'h055);
    i_host.push(w(4'h0, 9'h1ff, 9'h1ff));
    i_host.push(w(4'h6, 9'h003, 9'h0f0));
    ex(dwd_pkg::DWD_ACT_AZ, 8'h12, 8'h34, 7'h10);
    check("az dx", c.dx, 9'h003);
  endtask
  // a non-special code raises the error, the eight listed ones do not
  task automatic s_spec();
    i_host.push(w(4'h2, 9'h001, 9'h000));
    ex(dwd_pkg::DWD_ACT_POINT, 8'h12, 8'h34, 7'h40);
    ex(dwd_pkg::DWD_ACT_CHAR, 8'h12, 8'h34, 7'h01);
    check("bad special", special_err, 1'b1);
    for (i = 0; i < 8; i++) begin
      i_host.push(w(4'h2, {3'h0, spc[i]}, 9'h000));
      ex(dwd_pkg::DWD_ACT_POINT, 8'h12, 8'h34, 7'h40);
      ex(dwd_pkg::DWD_ACT_CHAR, 8'h12, 8'h34, {1'b0, spc[i]});
      check("special", special_err, 1'b0);
    end
    i_host.push(w(4'h6, 9'h010, 9'h000));
    ex(dwd_pkg::DWD_ACT_AZ, 8'h12, 8'h34, 7'h10);
  endtask
  task automatic s_chars();
    i_host.push(w(4'h3, 9'h005, 9'h00a));
    ex(dwd_pkg::DWD_ACT_POINT, 8'h12, 8'h34, 7'h40);
    ex(dwd_pkg::DWD_ACT_CHAR, 8'h1a, 8'h34, 7'h05);
    ex(dwd_pkg::DWD_ACT_CHAR, 8'h22, 8'h34, 7'h0a);
    i_host.push(w(4'h3, 9'h000, 9'h00a));
    ex(dwd_pkg::DWD_ACT_POINT, 8'h12, 8'h34, 7'h40);
    ex(dwd_pkg::DWD_ACT_CHAR, 8'h22, 8'h34, 7'h0a);
    i_host.push(w(4'h1, 9'h020, 9'h040));
    i_host.push(w(4'h4, 9'h005, 9'h000));
    ex(dwd_pkg::DWD_ACT_CHAR, 8'h28, 8'h40, 7'h05);
    i_host.push(w(4'ha, 9'h00b, 9'h000));
    ex(dwd_pkg::DWD_ACT_POINT, 8'h20, 8'h40, 7'h40);
    ex(dwd_pkg::DWD_ACT_CHAR, 8'h20, 8'h40, 7'h0b);
    check("flash", c.flash, 1'b1);
    i_host.push(w(4'h7, 9'h0c8, 9'h0c8));
    ex(dwd_pkg::DWD_ACT_CIRC, 8'h20, 8'h40, 7'h40);
    check("radius", {c.dx, c.dy}, {9'h0c8, 9'h0c8});
  endtask
  // end of data holds decoding back until the next frame
  task automatic s_eod();
    i_host.push(w(4'h8, 9'h000, 9'h000));
    i_host.push(w(4'h5, 9'h001, 9'h002));
    @(negedge sys_clk) cmd_ready = 1;
    repeat (30) @(negedge sys_clk);
    check("held", cmd_valid, 1'b0);
    check("dark", video_en, 1'b0);
    check("done", frame_done, 1'b1);
    frame_start = 1;
    repeat (2) @(negedge sys_clk);
    frame_start = 0;
    ex(dwd_pkg::DWD_ACT_VEC, 8'h20, 8'h40, 7'h40);
  endtask
  // stalled plotter: the fifo fills and refuses, then drains in order
  task automatic s_fill();
    for (i = 0; i < 24; i++) i_host.push(w(4'h5, 9'(i), 9'h000));
    repeat (100) @(negedge sys_clk);
    check("full", word_req, 1'b0);
    check("refused", taken, 32'd39);
    check("lit", video_en, 1'b1);
    for (i = 0; i < 24; i++) begin
      ex(dwd_pkg::DWD_ACT_VEC, 8'h20, 8'h40, 7'h40);
      check("order", c.dx, 9'(i));
    end
  endtask
  initial begin
    rst = 1;
    frame_start = 0;
    cmd_ready = 0;
    err_count = 0;
    n_checks = 0;
    repeat (8) @(negedge sys_clk);
    rst = 0;
    s_vec();
    s_spec();
    s_chars();
    s_eod();
    s_fill();
    report_and_stop();
  end
endmodule
